// *** exec_pkg.sv ***
/*
 * Shared types and constants of the byte/word execution unit.
 * Assumes one 50 MHz core clock; all users refer to exec_pkg::name.
 */
`default_nettype none
package exec_pkg;

    // ************************************************
    // widths and fixed values
    // ************************************************
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam int BYTE_MSB = 7;
    localparam int NIBBLE_MSB = 3;
    localparam int WORD_MSB = 15;

    // ************************************************
    // cycle counts and program counter steps
    // ************************************************
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [15:0] STEP_NEXT = 16'h0001;
    localparam logic [15:0] STEP_SKIP_ONE = 16'h0002;
    localparam logic [15:0] STEP_SKIP_TWO = 16'h0003;

    // ************************************************
    // operations
    // ************************************************
    typedef enum logic [4:0] {
        op_add,
        op_add_carry,
        add_immediate_word,
        subtract_immediate_word,
        subtract_with_borrow,
        subtract_immediate_with_borrow,
        subtract_immediate,
        and_with_immediate,
        or_with_immediate,
        clear_bits_by_mask,
        test_sign_zero,
        product_unsigned,
        product_signed,
        product_signed_by_unsigned,
        fractional_product_unsigned,
        fractional_product_signed,
        fractional_product_mixed,
        compare_immediate,
        skip_on_clear_register_bit,
        skip_on_equal_compare,
        indirect_jump,
        indirect_call
    } op_type;

    // ************************************************
    // carriers
    // ************************************************
    typedef struct packed {
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } flags_type;

    // flag masks, order h s v n z c
    localparam flags_type MASK_ARITH = 6'h2F;
    localparam flags_type MASK_LOGIC = 6'h0E;
    localparam flags_type MASK_WORD = 6'h1F;
    localparam flags_type MASK_MUL = 6'h03;
    localparam flags_type MASK_NONE = 6'h00;

    typedef struct packed {
        op_type op;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] imm;
        logic [15:0] pair;
        logic [15:0] pointer;
        logic [15:0] pc;
        logic [2:0] bit_sel;
        logic carry;
        logic next_two_word;
    } operand_type;

    typedef struct packed {
        logic [7:0] byte_val;
        logic byte_write;
        logic [15:0] word_val;
        logic word_write;
        logic product_write;
        logic [15:0] pc_val;
        logic pc_write;
        logic [15:0] push_val;
        logic push_write;
        flags_type flags;
        flags_type flag_mask;
    } result_type;

endpackage : exec_pkg
`default_nettype wire

// *** exec_unit.sv ***
/*
 * Execution unit for byte arithmetic/logic, word immediate ops,
 * multiplies, skips and indirect jump/call.
 * Assumes operands are read from the register file by the caller
 * on the same clock and that results are written back by it.
 */
// What this block does
// RQ1 - add and add-with-carry, five flags, one cycle
// RQ2 - word immediate add on pair, two cycles
// RQ3 - word immediate subtract on pair, two cycles
// RQ4 - register subtract with borrow, one cycle
// RQ5 - immediate subtract with borrow, one cycle
// RQ6 - immediate subtract, five flags, one cycle
// RQ7 - and immediate, z n v only
// RQ8 - or immediate, z n v only
// RQ9 - clear bits using ones minus mask
// RQ10 - test register, value unchanged, z n v
// RQ11 - byte multiplies into product pair, two cycles
// RQ12 - fractional multiplies shift product left one
// RQ13 - compare immediate sets flags, no write
// RQ14 - skip when register bit clear
// RQ15 - skip when two registers equal
// RQ16 - indirect jump from pointer, two cycles
// RQ17 - indirect call from pointer, three cycles
// RQ18 - call pushes next address in the same result as the redirect
// RQ19 - skip size follows skipped instruction length
`timescale 1ns/1ns
`default_nettype none
module exec_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request
    input wire logic start,
    input wire exec_pkg::operand_type operand,
    // answer
    output logic busy_reg,
    output logic done_reg,
    output var exec_pkg::result_type result_reg
);

    // ************************************************
    // helpers
    // ************************************************
    function automatic exec_pkg::flags_type byte_flags(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic [7:0] r,
        input logic carry_out,
        input logic is_sub
    );
        exec_pkg::flags_type f;
        logic a3, b3, r3, a7, b7, r7;
        a3 = a[exec_pkg::NIBBLE_MSB];
        b3 = b[exec_pkg::NIBBLE_MSB];
        r3 = r[exec_pkg::NIBBLE_MSB];
        a7 = a[exec_pkg::BYTE_MSB];
        b7 = b[exec_pkg::BYTE_MSB];
        r7 = r[exec_pkg::BYTE_MSB];
        if (is_sub) begin
            f.h = (~a3 & b3) | (b3 & r3) | (r3 & ~a3);
            f.v = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
        end else begin
            f.h = (a3 & b3) | (b3 & ~r3) | (~r3 & a3);
            f.v = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
        end
        f.n = r7;
        f.z = (r == exec_pkg::BYTE_ZERO);
        f.c = carry_out;
        f.s = f.n ^ f.v;
        return f;
    endfunction : byte_flags

    // ************************************************
    // operation decode and compute
    // ************************************************
    exec_pkg::result_type nres;
    logic [1:0] ncyc;

    always_comb begin : compute
        logic [8:0] sum9;
        logic [7:0] b;
        logic cin;
        logic [16:0] w17;
        logic [15:0] ax;
        logic [15:0] bx;
        logic [31:0] p32;
        logic [15:0] prod;
        logic take;
        exec_pkg::flags_type f;
        sum9 = '0;
        b = '0;
        cin = 1'b0;
        w17 = '0;
        ax = '0;
        bx = '0;
        p32 = '0;
        prod = '0;
        take = 1'b0;
        f = '0;
        nres = '0;
        ncyc = exec_pkg::CYC_ONE;
        case (operand.op)
            exec_pkg::op_add, exec_pkg::op_add_carry: begin
                cin = (operand.op == exec_pkg::op_add_carry) & operand.carry; // RQ1
                sum9 = {1'b0, operand.dst} + {1'b0, operand.src}
                    + {8'h00, cin};
                nres.byte_val = sum9[7:0];
                nres.byte_write = 1'b1;
                nres.flags = byte_flags(operand.dst, operand.src,
                    sum9[7:0], sum9[8], 1'b0);
                nres.flag_mask = exec_pkg::MASK_ARITH; // RQ1
            end
            exec_pkg::subtract_with_borrow,
            exec_pkg::subtract_immediate_with_borrow,
            exec_pkg::subtract_immediate,
            exec_pkg::compare_immediate: begin
                b = (operand.op == exec_pkg::subtract_with_borrow) ?
                    operand.src : operand.imm; // RQ4
                cin = operand.carry & (
                    operand.op == exec_pkg::subtract_with_borrow ||
                    operand.op == exec_pkg::subtract_immediate_with_borrow
                ); // RQ5
                sum9 = {1'b0, operand.dst} - {1'b0, b} - {8'h00, cin}; // RQ6
                nres.byte_val = sum9[7:0];
                // compare only leaves its flags behind
                nres.byte_write =
                    (operand.op != exec_pkg::compare_immediate); // RQ13
                nres.flags = byte_flags(operand.dst, b, sum9[7:0],
                    sum9[8], 1'b1);
                nres.flag_mask = exec_pkg::MASK_ARITH;
            end
            exec_pkg::and_with_immediate, exec_pkg::or_with_immediate,
            exec_pkg::clear_bits_by_mask, exec_pkg::test_sign_zero: begin
                case (operand.op)
                    exec_pkg::and_with_immediate:
                        b = operand.dst & operand.imm; // RQ7
                    exec_pkg::or_with_immediate:
                        b = operand.dst | operand.imm; // RQ8
                    exec_pkg::clear_bits_by_mask:
                        b = operand.dst
                            & (exec_pkg::ALL_ONES - operand.imm); // RQ9
                    default:
                        b = operand.dst & operand.dst; // RQ10
                endcase
                nres.byte_val = b;
                nres.byte_write = 1'b1;
                f.n = b[exec_pkg::BYTE_MSB];
                f.z = (b == exec_pkg::BYTE_ZERO);
                f.v = 1'b0;
                f.s = f.n;
                nres.flags = f;
                // carry and half carry stay as they were
                nres.flag_mask = exec_pkg::MASK_LOGIC; // RQ7
            end
            exec_pkg::add_immediate_word,
            exec_pkg::subtract_immediate_word: begin
                if (operand.op == exec_pkg::add_immediate_word) begin
                    w17 = {1'b0, operand.pair} + {9'h000, operand.imm}; // RQ2
                    f.v = ~operand.pair[exec_pkg::WORD_MSB]
                        & w17[exec_pkg::WORD_MSB];
                    f.c = ~w17[exec_pkg::WORD_MSB]
                        & operand.pair[exec_pkg::WORD_MSB];
                end else begin
                    w17 = {1'b0, operand.pair} - {9'h000, operand.imm}; // RQ3
                    f.v = operand.pair[exec_pkg::WORD_MSB]
                        & ~w17[exec_pkg::WORD_MSB];
                    f.c = w17[exec_pkg::WORD_MSB]
                        & ~operand.pair[exec_pkg::WORD_MSB];
                end
                f.n = w17[exec_pkg::WORD_MSB];
                f.z = (w17[15:0] == exec_pkg::WORD_ZERO);
                f.s = f.n ^ f.v;
                nres.flags = f;
                nres.flag_mask = exec_pkg::MASK_WORD;
                nres.word_val = w17[15:0];
                nres.word_write = 1'b1;
                ncyc = exec_pkg::CYC_TWO; // RQ2
            end
            exec_pkg::product_unsigned, exec_pkg::product_signed,
            exec_pkg::product_signed_by_unsigned,
            exec_pkg::fractional_product_unsigned,
            exec_pkg::fractional_product_signed,
            exec_pkg::fractional_product_mixed: begin
                // low 16 bits of sign-extended operands give the
                // two's complement product without a signed multiplier
                ax = {8'h00, operand.dst};
                bx = {8'h00, operand.src};
                if (operand.op != exec_pkg::product_unsigned &&
                    operand.op != exec_pkg::fractional_product_unsigned) begin
                    ax = {{8{operand.dst[exec_pkg::BYTE_MSB]}}, operand.dst};
                end
                if (operand.op == exec_pkg::product_signed ||
                    operand.op == exec_pkg::fractional_product_signed) begin
                    bx = {{8{operand.src[exec_pkg::BYTE_MSB]}}, operand.src};
                end
                p32 = ax * bx; // RQ11
                prod = p32[15:0];
                f.c = prod[exec_pkg::WORD_MSB];
                if (operand.op == exec_pkg::fractional_product_unsigned ||
                    operand.op == exec_pkg::fractional_product_signed ||
                    operand.op == exec_pkg::fractional_product_mixed) begin
                    prod = {prod[14:0], 1'b0}; // RQ12
                end
                f.z = (prod == exec_pkg::WORD_ZERO);
                nres.flags = f;
                nres.flag_mask = exec_pkg::MASK_MUL; // RQ11
                nres.word_val = prod;
                nres.product_write = 1'b1;
                ncyc = exec_pkg::CYC_TWO;
            end
            exec_pkg::skip_on_clear_register_bit,
            exec_pkg::skip_on_equal_compare: begin
                if (operand.op == exec_pkg::skip_on_clear_register_bit) begin
                    take = ~operand.src[operand.bit_sel]; // RQ14
                end else begin
                    take = (operand.dst == operand.src); // RQ15
                end
                nres.pc_write = 1'b1;
                nres.flag_mask = exec_pkg::MASK_NONE;
                if (!take) begin
                    nres.pc_val = operand.pc + exec_pkg::STEP_NEXT;
                end else if (operand.next_two_word) begin
                    nres.pc_val = operand.pc + exec_pkg::STEP_SKIP_TWO; // RQ19
                    ncyc = exec_pkg::CYC_THREE;
                end else begin
                    nres.pc_val = operand.pc + exec_pkg::STEP_SKIP_ONE; // RQ19
                    ncyc = exec_pkg::CYC_TWO;
                end
            end
            exec_pkg::indirect_jump: begin
                nres.pc_val = operand.pointer; // RQ16
                nres.pc_write = 1'b1;
                ncyc = exec_pkg::CYC_TWO;
            end
            exec_pkg::indirect_call: begin
                nres.pc_val = operand.pointer; // RQ17
                nres.pc_write = 1'b1;
                nres.push_val = operand.pc + exec_pkg::STEP_NEXT; // RQ18
                nres.push_write = 1'b1;
                ncyc = exec_pkg::CYC_THREE; // RQ17
            end
            default: begin
                nres = '0;
            end
        endcase
    end

    // ************************************************
    // cycle sequencer
    // ************************************************
    typedef enum logic {idle, run} state_type;

    state_type state_reg, state_next;
    logic [1:0] cnt_reg, cnt_next;
    exec_pkg::result_type pend_reg, pend_next;
    exec_pkg::result_type result_next;
    exec_pkg::op_type op_reg, op_next;
    logic busy_next;
    logic done_next;
    logic accept;

    assign accept = start && (state_reg == idle);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        pend_next = pend_reg;
        result_next = result_reg;
        op_next = op_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        case (state_reg)
            idle: begin
                // requests during a multi-cycle op are ignored
                if (start) begin
                    op_next = operand.op;
                    if (ncyc == exec_pkg::CYC_ONE) begin
                        result_next = nres;
                        done_next = 1'b1;
                    end else begin
                        pend_next = nres;
                        cnt_next = ncyc - exec_pkg::CYC_ONE;
                        state_next = run;
                        busy_next = 1'b1;
                    end
                end
            end
            run: begin
                cnt_next = cnt_reg - exec_pkg::CYC_ONE;
                if (cnt_reg == exec_pkg::CYC_ONE) begin
                    result_next = pend_reg;
                    done_next = 1'b1;
                    busy_next = 1'b0;
                    state_next = idle;
                end
            end
            default: begin
                state_next = idle;
                busy_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= idle;
            cnt_reg <= '0;
            pend_reg <= '0;
            result_reg <= '0;
            op_reg <= exec_pkg::op_add;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pend_reg <= pend_next;
            result_reg <= result_next;
            op_reg <= op_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence wait_two_s;
        !done_reg ##1 done_reg;
    endsequence

    sequence wait_three_s;
        !done_reg ##1 !done_reg ##1 done_reg;
    endsequence

    add_result_a: assert property ( // RQ1
        accept && operand.op == exec_pkg::op_add |=>
        done_reg && result_reg.byte_write &&
        result_reg.byte_val == 8'($past(operand.dst) + $past(operand.src)))
        else $error("add result wrong");

    word_timing_a: assert property ( // RQ2
        accept && operand.op == exec_pkg::add_immediate_word |=>
        wait_two_s ##0 result_reg.word_write &&
        result_reg.word_val == 16'($past(operand.pair, 2)
        + {8'h00, $past(operand.imm, 2)}) &&
        result_reg.flags.s == (result_reg.flags.n ^ result_reg.flags.v))
        else $error("word add timing or sign wrong");

    borrow_sub_a: assert property ( // RQ4
        accept && operand.op == exec_pkg::subtract_with_borrow |=>
        done_reg && result_reg.byte_val ==
        8'($past(operand.dst) - $past(operand.src) - $past(operand.carry)))
        else $error("subtract with borrow wrong");

    logic_mask_a: assert property ( // RQ7
        done_reg && (op_reg == exec_pkg::and_with_immediate ||
        op_reg == exec_pkg::or_with_immediate) |->
        result_reg.flag_mask == exec_pkg::MASK_LOGIC &&
        !result_reg.flags.v)
        else $error("logic op touched carry flags");

    mul_timing_a: assert property ( // RQ11
        accept && operand.op == exec_pkg::product_unsigned |=>
        wait_two_s ##0 result_reg.product_write &&
        result_reg.flag_mask == exec_pkg::MASK_MUL)
        else $error("multiply timing or flags wrong");

    compare_nowrite_a: assert property ( // RQ13
        done_reg && op_reg == exec_pkg::compare_immediate |->
        !result_reg.byte_write &&
        result_reg.flag_mask == exec_pkg::MASK_ARITH)
        else $error("compare wrote register");

    skip_size_a: assert property ( // RQ19
        accept && operand.op == exec_pkg::skip_on_equal_compare &&
        operand.dst == operand.src && operand.next_two_word |=>
        wait_three_s ##0 result_reg.flag_mask == exec_pkg::MASK_NONE &&
        result_reg.pc_val ==
        16'($past(operand.pc, 3) + exec_pkg::STEP_SKIP_TWO))
        else $error("two-word skip timing wrong");

    jump_timing_a: assert property ( // RQ16
        accept && operand.op == exec_pkg::indirect_jump |=>
        wait_two_s ##0 result_reg.pc_write && !result_reg.push_write)
        else $error("indirect jump wrong");

    call_push_a: assert property ( // RQ18
        accept && operand.op == exec_pkg::indirect_call |=>
        wait_three_s ##0 result_reg.push_write &&
        result_reg.push_val == 16'($past(operand.pc, 3) + 16'h0001))
        else $error("call push address wrong");

endmodule : exec_unit
`default_nettype wire

// *** test_cpu_arith_logic_branch_exec.sv ***
/*
 * Self-checking bench for exec_unit: byte, word, multiply and branch
 * operations with their results, flags and cycle counts.
 * Assumes the unit alone on one 50 MHz clock; no partner model.
 */
`timescale 1ns/1ns
`default_nettype none
module test_cpu_arith_logic_branch_exec;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    exec_pkg::operand_type operand = '0;
    logic busy_reg;
    logic done_reg;
    exec_pkg::result_type r;
    int error_cnt = 0;
    int total_checks = 0;

    always #10 clk = ~clk;

    exec_unit u_exec_unit (
        .clk(clk),
        .rst(rst),
        .start(start),
        .operand(operand),
        .busy_reg(busy_reg),
        .done_reg(done_reg),
        .result_reg(r)
    );

    // ************************************************
    // helpers
    // ************************************************
    task automatic tally_and_finish;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // request taken at the first rising edge; count edges up to done
    task automatic go(input exec_pkg::op_type op, input logic [7:0] d,
                      input logic [7:0] s, input logic c, input int cyc);
        int n;
        // idle cycle first, so start is never lowered and raised at once
        @(negedge clk);
        chk("done_pulse", {15'h0000, done_reg}, 16'h0000);
        operand.op = op;
        operand.dst = d;
        operand.src = s;
        operand.imm = s;
        operand.carry = c;
        start = 1'b1;
        @(posedge clk);
        n = 1;
        @(negedge clk);
        start = 1'b0;
        chk("busy", {15'h0000, busy_reg},
            (cyc > 1) ? 16'h0001 : 16'h0000);
        while (done_reg !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
            @(negedge clk);
        end
        if (n >= 8) begin
            error_cnt++;
            tally_and_finish;
        end else begin
            chk("cycles", 16'(n), 16'(cyc));
            chk("busy_end", {15'h0000, busy_reg}, 16'h0000);
        end
    endtask : go

    task automatic fl(input logic [5:0] m, input logic [5:0] f);
        chk("flag_mask", {10'h000, r.flag_mask}, {10'h000, m});
        chk("flags", {10'h000, r.flags & r.flag_mask}, {10'h000, f});
    endtask : fl

    task automatic bw(input logic [7:0] v);
        chk("byte", {7'h00, r.byte_write, r.byte_val}, {7'h01, v});
    endtask : bw

    task automatic wv(input logic [15:0] v, input logic wr);
        chk("word", r.word_val, v);
        chk("word_wr", {15'h0000, wr}, 16'h0001);
    endtask : wv

    task automatic mulchk(input exec_pkg::op_type op, input logic [7:0] d,
                          input logic [7:0] s, input logic [15:0] p,
                          input logic [5:0] f);
        go(op, d, s, 1'b0, 2);
        wv(p, r.product_write);
        fl(exec_pkg::MASK_MUL, f);
    endtask : mulchk

    // ************************************************
    // scenarios
    // ************************************************
    // carry in set on the plain add: it must not be added
    task automatic arith_add;
        go(exec_pkg::op_add, 8'h0F, 8'h01, 1'b1, 1);
        bw(8'h10);
        fl(exec_pkg::MASK_ARITH, 6'h20);
        go(exec_pkg::op_add_carry, 8'h7F, 8'h00, 1'b1, 1);
        bw(8'h80);
        fl(exec_pkg::MASK_ARITH, 6'h2C);
    endtask : arith_add

    task automatic sub_family;
        go(exec_pkg::subtract_immediate, 8'h00, 8'h01, 1'b1, 1);
        bw(8'hFF);
        fl(exec_pkg::MASK_ARITH, 6'h25);
        go(exec_pkg::subtract_with_borrow, 8'h80, 8'h00, 1'b1, 1);
        bw(8'h7F);
        fl(exec_pkg::MASK_ARITH, 6'h28);
        go(exec_pkg::subtract_immediate_with_borrow, 8'h10, 8'h0F, 1'b1,
           1);
        bw(8'h00);
        fl(exec_pkg::MASK_ARITH, 6'h22);
        go(exec_pkg::compare_immediate, 8'h05, 8'h05, 1'b1, 1);
        chk("cmp_wr", {15'h0000, r.byte_write}, 16'h0000);
        fl(exec_pkg::MASK_ARITH, 6'h02);
    endtask : sub_family

    task automatic logic_ops;
        go(exec_pkg::and_with_immediate, 8'h8F, 8'hF0, 1'b1, 1);
        bw(8'h80);
        fl(exec_pkg::MASK_LOGIC, 6'h04);
        go(exec_pkg::or_with_immediate, 8'h00, 8'h00, 1'b1, 1);
        bw(8'h00);
        fl(exec_pkg::MASK_LOGIC, 6'h02);
        go(exec_pkg::clear_bits_by_mask, 8'hFF, 8'h0F, 1'b0, 1);
        bw(8'hF0);
        fl(exec_pkg::MASK_LOGIC, 6'h04);
        // source left zero so a wrong operand shows up as zero flag
        go(exec_pkg::test_sign_zero, 8'h80, 8'h00, 1'b0, 1);
        chk("tst_val", {8'h00, r.byte_val}, 16'h0080);
        fl(exec_pkg::MASK_LOGIC, 6'h04);
    endtask : logic_ops

    task automatic word_ops;
        operand.pair = 16'hFFFF;
        go(exec_pkg::add_immediate_word, 8'h00, 8'h01, 1'b0, 2);
        wv(16'h0000, r.word_write);
        fl(exec_pkg::MASK_WORD, 6'h03);
        operand.pair = 16'h8000;
        go(exec_pkg::subtract_immediate_word, 8'h00, 8'h01, 1'b1, 2);
        wv(16'h7FFF, r.word_write);
        fl(exec_pkg::MASK_WORD, 6'h18);
    endtask : word_ops

    task automatic mul_ops;
        mulchk(exec_pkg::product_unsigned, 8'hFF, 8'hFF, 16'hFE01,
               6'h01);
        mulchk(exec_pkg::product_signed, 8'hFF, 8'hFF, 16'h0001,
               6'h00);
        mulchk(exec_pkg::product_signed_by_unsigned, 8'hFF, 8'h02,
               16'hFFFE, 6'h01);
        mulchk(exec_pkg::fractional_product_unsigned, 8'h80, 8'h80,
               16'h8000, 6'h00);
        mulchk(exec_pkg::fractional_product_unsigned, 8'h00, 8'h55,
               16'h0000, 6'h02);
        mulchk(exec_pkg::fractional_product_signed, 8'h80, 8'h80,
               16'h8000, 6'h00);
        mulchk(exec_pkg::fractional_product_mixed, 8'h80, 8'h80,
               16'h8000, 6'h01);
    endtask : mul_ops

    task automatic branch_ops;
        operand.pc = 16'h0100;
        operand.pointer = 16'h1234;
        operand.next_two_word = 1'b0;
        operand.bit_sel = 3'h2;
        go(exec_pkg::skip_on_clear_register_bit, 8'hFB, 8'hFB, 1'b0,
           2);
        chk("pc", r.pc_val, 16'h0102);
        fl(exec_pkg::MASK_NONE, 6'h00);
        operand.bit_sel = 3'h0;
        go(exec_pkg::skip_on_clear_register_bit, 8'hFB, 8'hFB, 1'b0,
           1);
        chk("pc", r.pc_val, 16'h0101);
        operand.next_two_word = 1'b1;
        go(exec_pkg::skip_on_equal_compare, 8'h5A, 8'h5A, 1'b0,
           3);
        chk("pc", r.pc_val, 16'h0103);
        fl(exec_pkg::MASK_NONE, 6'h00);
        go(exec_pkg::skip_on_equal_compare, 8'h5A, 8'h5B, 1'b0, 1);
        chk("pc", r.pc_val, 16'h0101);
        go(exec_pkg::indirect_jump, 8'h00, 8'h00, 1'b0, 2);
        chk("pc", r.pc_val, 16'h1234);
        fl(exec_pkg::MASK_NONE, 6'h00);
        go(exec_pkg::indirect_call, 8'h00, 8'h00, 1'b0, 3);
        chk("pc", r.pc_val, 16'h1234);
        chk("push", {r.push_write, r.push_val[14:0]}, 16'h8101);
        fl(exec_pkg::MASK_NONE, 6'h00);
    endtask : branch_ops

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        arith_add;
        sub_family;
        logic_ops;
        word_ops;
        mul_ops;
        branch_ops;
        tally_and_finish;
    end
endmodule : test_cpu_arith_logic_branch_exec
`default_nettype wire
